/* File: rtl/charger_regs_pkg.sv */
// Purpose: Shared constants and carriers for the charger control/status register bank
// Assumes: 200 MHz core clock, 8-bit registers at offsets 00..03
// Notes:   Event pulse width is derived from its time in nanoseconds
package charger_regs_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned EVT_PULSE_NS    = 128000;
  localparam int unsigned EVT_PULSE_CYC   = (EVT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] OFS_STATE_FAULT  = 8'h00;
  localparam logic [7:0] OFS_SUPPLY_BATT  = 8'h01;
  localparam logic [7:0] OFS_CONTROL      = 8'h02;
  localparam logic [7:0] OFS_VREG_ILIM    = 8'h03;

  localparam logic [7:0] RST_CONTROL      = 8'h8C;
  localparam logic [7:0] RST_VREG_ILIM    = 8'h14;
  localparam logic       RST_NO_CELL_OP   = 1'b0;

  localparam int unsigned BIT_KICK        = 7;
  localparam int unsigned BIT_SOFT_RESET  = 7;
  localparam int unsigned BIT_STAT_EN     = 3;
  localparam int unsigned BIT_CUTOFF_EN   = 2;
  localparam int unsigned BIT_CHG_DIS     = 1;
  localparam int unsigned BIT_TRISTATE    = 0;
  localparam int unsigned BIT_NO_CELL_OP  = 0;
  localparam int unsigned BIT_ILIM_SEL    = 1;
  localparam int unsigned LSB_VREG        = 2;

  localparam logic [12:0] VREG_BASE_MV    = 13'd3500;
  localparam logic [12:0] VREG_STEP_MV    = 13'd20;
  localparam logic [12:0] ILIM_LOW_MA     = 13'd1500;
  localparam logic [12:0] ILIM_HIGH_MA    = 13'd2500;

  typedef enum logic [2:0] {
    PH_NO_SOURCE = 3'b000,
    PH_IN_READY  = 3'b001,
    PH_CHARGING  = 3'b011,
    PH_DONE      = 3'b101,
    PH_FAULT     = 3'b111
  } phase_t;

  typedef enum logic [2:0] {
    FLT_NONE     = 3'b000,
    FLT_THERMAL  = 3'b001,
    FLT_BAT_TEMP = 3'b010,
    FLT_WATCHDOG = 3'b011,
    FLT_SAFETY   = 3'b100,
    FLT_SUPPLY   = 3'b101,
    FLT_BATTERY  = 3'b111
  } fault_t;

  // Condition codes reported by the analog core, same clock domain
  typedef struct packed {
    logic [2:0] phase;
    logic [2:0] fault;
    logic [1:0] supply_cond_code;
    logic [1:0] battery_cond_code;
  } core_status_t;

  // Controls handed to the analog core
  typedef struct packed {
    logic        no_cell_operation_en;
    logic        cell_overvoltage_guard;
    logic        reverse_boost_guard;
    logic        charge_cutoff_enable;
    logic        charge_disable;
    logic        tristate_idle;
    logic        converter_on;
    logic        batt_fet_on;
    logic        batt_fet_drive_on;
    logic        batt_fet_drive_hiz;
    logic        sys_regulate;
    logic [5:0]  cell_reg_voltage;
    logic [12:0] cell_reg_mv;
    logic        input_current_cap_sel;
    logic [12:0] input_limit_ma;
  } core_ctrl_t;

  // Register access request from the link side
  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

/* File: rtl/charger_control_status_regs.sv */
// Purpose: Host-visible control/status register bank of a single-cell charger
// Assumes: Register requests arrive on link_clk from the serial front end
// Notes:   Registers live in the core clock domain; requests cross by toggle handshake
`timescale 1ns/1ps
module charger_control_status_regs #(
  parameter int unsigned PULSE_CYCLES = charger_regs_pkg::EVT_PULSE_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       link_clk,
  input  wire logic                       req_valid,
  input  wire charger_regs_pkg::reg_req_t req,
  output logic                            req_ready,
  output logic                            rsp_valid,
  output logic [7:0]                      rsp_rdata,
  input  wire charger_regs_pkg::core_status_t core_status,
  output charger_regs_pkg::core_ctrl_t    core_ctrl,
  output logic                            watchdog_kick,
  output logic                            watchdog_stop,
  output logic                            stat_o,
  output logic                            stat_oe,
  output logic                            int_o,
  output logic                            int_oe
);
  import charger_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchronisers, one per domain

  logic rst_meta_ff, rst_sync_ff, lrst_meta_ff, lrst_sync_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_meta_ff <= 1'b0;
      lrst_sync_ff <= 1'b0;
    end else begin
      lrst_meta_ff <= 1'b1;
      lrst_sync_ff <= lrst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side: capture request, toggle, wait for answer toggle

  reg_req_t   hold_req_ff;
  logic       req_tgl_ff, busy_ff, rsp_valid_ff;
  logic [7:0] rsp_rdata_ff;
  logic       ack_meta_ff, ack_sync_ff, ack_seen_ff;
  logic       ack_tgl_ff;
  logic [7:0] rd_word_ff;

  assign req_ready = ~busy_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_rdata = rsp_rdata_ff;

  always_ff @(posedge link_clk or negedge lrst_sync_ff) begin
    if (!lrst_sync_ff) begin
      hold_req_ff  <= '0;
      req_tgl_ff   <= 1'b0;
      busy_ff      <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= 8'h00;
      ack_meta_ff  <= 1'b0;
      ack_sync_ff  <= 1'b0;
      ack_seen_ff  <= 1'b0;
    end else begin
      ack_meta_ff  <= ack_tgl_ff;
      ack_sync_ff  <= ack_meta_ff;
      rsp_valid_ff <= 1'b0;
      if (req_valid && !busy_ff) begin
        hold_req_ff <= req;
        req_tgl_ff  <= ~req_tgl_ff;
        busy_ff     <= 1'b1;
      end else if (busy_ff && (ack_sync_ff != ack_seen_ff)) begin
        // Read word was frozen before the answer toggle, so it is stable here
        ack_seen_ff  <= ack_sync_ff;
        busy_ff      <= 1'b0;
        rsp_valid_ff <= 1'b1;
        rsp_rdata_ff <= rd_word_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core side: request detection

  logic req_meta_ff, req_sync_ff, req_seen_ff;
  logic do_req;
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      req_meta_ff <= 1'b0;
      req_sync_ff <= 1'b0;
      req_seen_ff <= 1'b0;
    end else begin
      req_meta_ff <= req_tgl_ff;
      req_sync_ff <= req_meta_ff;
      req_seen_ff <= req_sync_ff;
    end
  end
  assign do_req = req_sync_ff ^ req_seen_ff;

  logic do_wr;
  assign do_wr = do_req & hold_req_ff.write;

  function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] ofs);
    wr_hit = w && (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Writable state

  logic       stat_en_ff, cutoff_en_ff, chg_dis_ff, tristate_ff, no_cell_ff;
  logic [5:0] vreg_ff;
  logic       ilim_ff;
  logic       soft_rst_ff, kick_ff, wd_stop_ff;
  logic       soft_rst_req;

  assign soft_rst_req = wr_hit(do_wr, hold_req_ff.addr, OFS_CONTROL)
                        && hold_req_ff.wdata[BIT_SOFT_RESET];

  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      stat_en_ff   <= RST_CONTROL[BIT_STAT_EN];
      cutoff_en_ff <= RST_CONTROL[BIT_CUTOFF_EN];
      chg_dis_ff   <= RST_CONTROL[BIT_CHG_DIS];
      tristate_ff  <= RST_CONTROL[BIT_TRISTATE];
      vreg_ff      <= RST_VREG_ILIM[7:LSB_VREG];
      ilim_ff      <= RST_VREG_ILIM[BIT_ILIM_SEL];
      no_cell_ff   <= RST_NO_CELL_OP;
    end else if (soft_rst_ff) begin
      stat_en_ff   <= RST_CONTROL[BIT_STAT_EN];
      cutoff_en_ff <= RST_CONTROL[BIT_CUTOFF_EN];
      chg_dis_ff   <= RST_CONTROL[BIT_CHG_DIS];
      tristate_ff  <= RST_CONTROL[BIT_TRISTATE];
      vreg_ff      <= RST_VREG_ILIM[7:LSB_VREG];
      ilim_ff      <= RST_VREG_ILIM[BIT_ILIM_SEL];
      no_cell_ff   <= RST_NO_CELL_OP;
    end else if (wr_hit(do_wr, hold_req_ff.addr, OFS_CONTROL) && !soft_rst_req) begin
      stat_en_ff   <= hold_req_ff.wdata[BIT_STAT_EN];
      cutoff_en_ff <= hold_req_ff.wdata[BIT_CUTOFF_EN];
      chg_dis_ff   <= hold_req_ff.wdata[BIT_CHG_DIS];
      tristate_ff  <= hold_req_ff.wdata[BIT_TRISTATE];
    end else if (wr_hit(do_wr, hold_req_ff.addr, OFS_VREG_ILIM)) begin
      vreg_ff      <= hold_req_ff.wdata[7:LSB_VREG];
      ilim_ff      <= hold_req_ff.wdata[BIT_ILIM_SEL];
    end else if (wr_hit(do_wr, hold_req_ff.addr, OFS_SUPPLY_BATT)) begin
      no_cell_ff   <= hold_req_ff.wdata[BIT_NO_CELL_OP];
    end
  end

  // Self-clearing strobes: reset, kick and watchdog stop last one cycle
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      soft_rst_ff <= 1'b0;
      kick_ff     <= 1'b0;
      wd_stop_ff  <= 1'b0;
    end else begin
      soft_rst_ff <= soft_rst_req;
      wd_stop_ff  <= soft_rst_req;
      kick_ff     <= wr_hit(do_wr, hold_req_ff.addr, OFS_STATE_FAULT)
                     && hold_req_ff.wdata[BIT_KICK];
    end
  end
  assign watchdog_kick = kick_ff;
  assign watchdog_stop = wd_stop_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Read path; the word is frozen one cycle before the answer toggle

  logic [7:0] rd_mux;
  always_comb begin
    if (hold_req_ff.addr == OFS_STATE_FAULT) begin
      rd_mux = {1'b0, core_status.phase, 1'b0, core_status.fault};
    end else if (hold_req_ff.addr == OFS_SUPPLY_BATT) begin
      rd_mux = {core_status.supply_cond_code, 3'b000,
                core_status.battery_cond_code, no_cell_ff};
    end else if (hold_req_ff.addr == OFS_CONTROL) begin
      rd_mux = {4'h0, stat_en_ff, cutoff_en_ff, chg_dis_ff, tristate_ff};
    end else if (hold_req_ff.addr == OFS_VREG_ILIM) begin
      rd_mux = {vreg_ff, ilim_ff, 1'b0};
    end else begin
      rd_mux = 8'h00;
    end
  end

  logic ans_pend_ff;
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rd_word_ff  <= 8'h00;
      ans_pend_ff <= 1'b0;
      ack_tgl_ff  <= 1'b0;
    end else begin
      ans_pend_ff <= do_req;
      if (do_req) begin
        rd_word_ff <= rd_mux;
      end
      if (ans_pend_ff) begin
        ack_tgl_ff <= ~ack_tgl_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Controls to the analog core

  always_comb begin
    core_ctrl.no_cell_operation_en   = no_cell_ff & ~cutoff_en_ff;
    core_ctrl.cell_overvoltage_guard = ~no_cell_ff;
    core_ctrl.reverse_boost_guard    = ~no_cell_ff;
    core_ctrl.charge_cutoff_enable   = cutoff_en_ff;
    core_ctrl.charge_disable         = chg_dis_ff;
    core_ctrl.tristate_idle          = tristate_ff;
    core_ctrl.converter_on           = ~tristate_ff;
    core_ctrl.batt_fet_on            = tristate_ff | ~chg_dis_ff;
    core_ctrl.batt_fet_drive_hiz     = chg_dis_ff & ~tristate_ff;
    core_ctrl.batt_fet_drive_on      = tristate_ff;
    core_ctrl.sys_regulate           = chg_dis_ff;
    core_ctrl.cell_reg_voltage       = vreg_ff;
    core_ctrl.cell_reg_mv            = VREG_BASE_MV + 13'(vreg_ff) * VREG_STEP_MV;
    core_ctrl.input_current_cap_sel  = ilim_ff;
    core_ctrl.input_limit_ma         = ilim_ff ? ILIM_HIGH_MA : ILIM_LOW_MA;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event detection and pulse timer

  core_status_t prev_ff;
  logic         primed_ff;
  logic         evt;
  logic [31:0]  pulse_cnt_ff;
  logic         pulse_on;

  // Plug/removal, supply or battery changes and any new nonzero fault qualify
  assign evt = primed_ff && (
                 ((core_status.phase == PH_NO_SOURCE) != (prev_ff.phase == PH_NO_SOURCE))
               || (core_status.supply_cond_code  != prev_ff.supply_cond_code)
               || (core_status.battery_cond_code != prev_ff.battery_cond_code)
               || ((core_status.fault != prev_ff.fault) && (core_status.fault != FLT_NONE)));

  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      prev_ff   <= '0;
      primed_ff <= 1'b0;
    end else begin
      prev_ff   <= core_status;
      primed_ff <= 1'b1;
    end
  end

  assign pulse_on = (pulse_cnt_ff != 32'd0);

  // A busy timer ignores new events so a pulse is never stretched
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pulse_cnt_ff <= 32'd0;
    end else if (pulse_on) begin
      pulse_cnt_ff <= pulse_cnt_ff - 32'd1;
    end else if (evt) begin
      pulse_cnt_ff <= 32'(PULSE_CYCLES);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain status and interrupt pins

  logic pin_low_ff;
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pin_low_ff <= 1'b0;
    end else begin
      pin_low_ff <= pulse_on || (stat_en_ff && (core_status.phase == PH_CHARGING));
    end
  end
  assign stat_o  = 1'b0;
  assign stat_oe = pin_low_ff;
  assign int_o   = 1'b0;
  assign int_oe  = pin_low_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_pulse_width: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (!pulse_on && evt) |=> pulse_on [*8])
    else $error("event pulse shorter than expected");
  chk_pulse_stretch: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (pulse_on && evt) |=> ($past(pulse_cnt_ff) - 32'd1 == pulse_cnt_ff))
    else $error("event during pulse changed the timer");
  chk_pin_mirror: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (int_oe == stat_oe) && (int_o == stat_o))
    else $error("interrupt pin differs from status pin");
  chk_charge_low: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (stat_en_ff && core_status.phase == PH_CHARGING) |=> stat_oe)
    else $error("status pin not low while charging");
  chk_idle_release: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (!pulse_on && !(stat_en_ff && core_status.phase == PH_CHARGING)) |=> !stat_oe)
    else $error("status pin driven without cause");
  chk_soft_reset: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    soft_rst_req |=> ##1 (stat_en_ff && cutoff_en_ff && !chg_dis_ff && !no_cell_ff
      && vreg_ff == RST_VREG_ILIM[7:LSB_VREG]))
    else $error("soft reset did not restore defaults");
  chk_reset_clears: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    soft_rst_ff |=> !soft_rst_ff)
    else $error("reset bit did not clear itself");
  chk_kick_pulse: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    $rose(watchdog_kick) |=> !watchdog_kick)
    else $error("watchdog kick held longer than one cycle");
  chk_no_cell_guard: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    core_ctrl.no_cell_operation_en |-> !core_ctrl.cell_overvoltage_guard
      && !core_ctrl.charge_cutoff_enable)
    else $error("no-battery operation with guard or termination on");
  chk_chg_disable: assert property (@(posedge clk) disable iff (!rst_sync_ff)
    (chg_dis_ff && !tristate_ff) |-> core_ctrl.batt_fet_drive_hiz && !core_ctrl.batt_fet_on)
    else $error("charge disable did not release gate drive");

endmodule

/* File: verif/charger_host_model.sv */
// Purpose: Link-side register master standing in for the serial front end
// Assumes: One request outstanding, answer marked by a one-cycle rsp_valid
// Notes:   Idle request lines show the inverse of the last request, never a stale copy
`timescale 1ns/1ps
module charger_host_model (
  input  wire logic                       link_clk,
  output logic                            req_valid,
  output charger_regs_pkg::reg_req_t      req,
  input  wire logic                       req_ready,
  input  wire logic                       rsp_valid,
  input  wire logic [7:0]                 rsp_rdata
);
  import charger_regs_pkg::*;

  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // Request held steady until the edge that takes it; gap makes the host slow
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        input int gap, output logic [7:0] q, output logic ok);
    int n;
    ok = 1'b0;
    q  = 8'h00;
    repeat (gap) @(negedge link_clk);
    @(negedge link_clk);
    req_valid = 1'b1;
    req       = '{write: wr, addr: a, wdata: d};
    n = 0;
    while (req_ready !== 1'b1 && n < 40) begin
      @(negedge link_clk);
      n++;
    end
    @(negedge link_clk);
    req_valid = 1'b0;
    req       = reg_req_t'(~req);
    while (rsp_valid !== 1'b1 && n < 80) begin
      @(negedge link_clk);
      n++;
    end
    q  = rsp_rdata;
    ok = (n < 80);
  endtask
endmodule

/* File: verif/charger_control_status_regs_tb_top.sv */
// Purpose: Self-checking bench for the charger register bank
// Assumes: Short event pulse for simulation, link clock 6 ns against core 5 ns
// Notes:   Pin mirror is watched every core cycle, strobes are counted by monitors
`timescale 1ns/1ps
module charger_control_status_regs_tb_top;
  import charger_regs_pkg::*;
  localparam int unsigned PW = 20;
  localparam logic [2:0] PH_TAB [5] = '{PH_NO_SOURCE, PH_IN_READY, PH_CHARGING, PH_DONE, PH_FAULT};
  localparam logic [2:0] FL_TAB [7] = '{FLT_NONE, FLT_THERMAL, FLT_BAT_TEMP, FLT_WATCHDOG,
                                        FLT_SAFETY, FLT_SUPPLY, FLT_BATTERY};
  logic         clk;
  logic         link_clk;
  logic         rst_n;
  logic         req_valid;
  reg_req_t     req;
  logic         req_ready;
  logic         rsp_valid;
  logic [7:0]   rsp_rdata;
  core_status_t core_status;
  core_ctrl_t   core_ctrl;
  logic         watchdog_kick;
  logic         watchdog_stop;
  logic         stat_o;
  logic         stat_oe;
  logic         int_o;
  logic         int_oe;
  logic [7:0]   rd_q;
  logic         ok;
  int           num_errors = 0;
  int           cmp_count = 0;
  int           kick_cnt = 0;
  int           stop_cnt = 0;
  int           len;

  charger_control_status_regs #(.PULSE_CYCLES(PW)) dut_u (
    .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .core_status(core_status), .core_ctrl(core_ctrl), .watchdog_kick(watchdog_kick),
    .watchdog_stop(watchdog_stop), .stat_o(stat_o), .stat_oe(stat_oe), .int_o(int_o),
    .int_oe(int_oe));

  charger_host_model host_u (
    .link_clk(link_clk), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strobes are counted away from the edge that launches them
  always @(negedge clk) begin
    if (watchdog_kick === 1'b1) kick_cnt++;
    if (watchdog_stop === 1'b1) stop_cnt++;
  end
  always @(negedge clk) begin
    if (rst_n === 1'b1) check("pin mirror", 16'({int_oe, int_o, stat_o}), 16'({stat_oe, 2'h0}));
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Any lost answer ends the run here rather than hanging
  task automatic rw(input logic wr, input logic [7:0] a, input logic [7:0] d, input int gap);
    host_u.access(wr, a, d, gap, rd_q, ok);
    if (ok !== 1'b1) begin
      num_errors++;
      report_and_stop();
    end
  endtask

  function automatic logic [15:0] ctl_bits();
    return 16'({core_ctrl.no_cell_operation_en, core_ctrl.cell_overvoltage_guard,
                core_ctrl.reverse_boost_guard, core_ctrl.charge_cutoff_enable,
                core_ctrl.charge_disable, core_ctrl.tristate_idle, core_ctrl.converter_on,
                core_ctrl.batt_fet_on, core_ctrl.batt_fet_drive_on,
                core_ctrl.batt_fet_drive_hiz, core_ctrl.sys_regulate});
  endfunction

  // Waits for a pulse, changes a code mid-pulse, and counts the low cycles
  task automatic pulse_len();
    int n;
    n   = 0;
    len = 0;
    while (stat_oe !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    if (stat_oe !== 1'b1) begin
      num_errors++;
      report_and_stop();
    end
    while (stat_oe === 1'b1 && len < 4 * PW) begin
      @(negedge clk);
      len++;
      if (len == 5) core_status.battery_cond_code = core_status.battery_cond_code ^ 2'h1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rw(1'b0, OFS_CONTROL, 8'h00, 0);
    check("ctl reset", 16'(rd_q), 16'(RST_CONTROL & 8'h7F));
    rw(1'b0, OFS_VREG_ILIM, 8'h00, 3);
    check("vreg reset", 16'(rd_q), 16'(RST_VREG_ILIM));
    check("mv reset", 16'(core_ctrl.cell_reg_mv), 16'(VREG_BASE_MV + VREG_STEP_MV * 13'h005));
    check("ma reset", 16'(core_ctrl.input_limit_ma), 16'(ILIM_LOW_MA));
  endtask

  task automatic t_codes();
    rw(1'b1, OFS_STATE_FAULT, 8'h7F, 0);
    check("no kick", 16'(kick_cnt), 16'h0000);
    for (int i = 0; i < 7; i++) begin
      @(negedge clk);
      core_status = '{phase: PH_TAB[i % 5], fault: FL_TAB[i], supply_cond_code: 2'(i),
                      battery_cond_code: 2'(i % 3)};
      rw(1'b0, OFS_STATE_FAULT, 8'h00, i % 2);
      check("state", 16'(rd_q), 16'({1'b0, PH_TAB[i % 5], 1'b0, FL_TAB[i]}));
      rw(1'b0, OFS_SUPPLY_BATT, 8'h00, 0);
      check("cond", 16'(rd_q), 16'({2'(i), 3'h0, 2'(i % 3), 1'b0}));
    end
  endtask

  task automatic t_rw();
    @(negedge clk);
    core_status = '0;
    rw(1'b1, OFS_VREG_ILIM, 8'hFF, 0);
    rw(1'b0, OFS_VREG_ILIM, 8'h00, 0);
    check("vreg all", 16'(rd_q), 16'h00FE);
    check("mv top", 16'(core_ctrl.cell_reg_mv), 16'(VREG_BASE_MV + VREG_STEP_MV * 13'h03F));
    check("ma high", 16'(core_ctrl.input_limit_ma), 16'(ILIM_HIGH_MA));
    check("vreg code", 16'({core_ctrl.cell_reg_voltage, core_ctrl.input_current_cap_sel}), 16'h007F);
    rw(1'b1, OFS_VREG_ILIM, 8'h00, 0);
    check("mv base", 16'(core_ctrl.cell_reg_mv), 16'(VREG_BASE_MV));
    rw(1'b1, OFS_SUPPLY_BATT, 8'hFF, 0);
    rw(1'b0, OFS_SUPPLY_BATT, 8'h00, 0);
    check("nocell rd", 16'(rd_q), 16'h0001);
    rw(1'b1, OFS_CONTROL, 8'h7B, 0);
    rw(1'b0, OFS_CONTROL, 8'h00, 0);
    check("ctl rd", 16'(rd_q), 16'h000B);
    check("ctl hiz", ctl_bits(), 16'h046D);
    rw(1'b1, OFS_CONTROL, 8'h06, 0);
    check("ctl dis", ctl_bits(), 16'h00D3);
    rw(1'b1, 8'h05, 8'hFF, 0);
    rw(1'b0, 8'h05, 8'h00, 0);
    check("unmapped", 16'(rd_q), 16'h0000);
  endtask

  task automatic t_soft_reset();
    check("no stop", 16'(stop_cnt), 16'h0000);
    rw(1'b1, OFS_CONTROL, 8'h83, 0);
    repeat (10) @(negedge clk);
    check("stop", 16'(stop_cnt), 16'h0001);
    rw(1'b0, OFS_CONTROL, 8'h00, 0);
    check("ctl back", 16'(rd_q), 16'(RST_CONTROL & 8'h7F));
    rw(1'b0, OFS_VREG_ILIM, 8'h00, 0);
    check("vreg back", 16'(rd_q), 16'(RST_VREG_ILIM));
    rw(1'b0, OFS_SUPPLY_BATT, 8'h00, 0);
    check("nocell back", 16'(rd_q), 16'h0000);
  endtask

  task automatic t_kick();
    rw(1'b1, OFS_STATE_FAULT, 8'h80, 0);
    rw(1'b1, OFS_STATE_FAULT, 8'h80, 0);
    repeat (10) @(negedge clk);
    check("kicks", 16'(kick_cnt), 16'h0002);
    rw(1'b0, OFS_STATE_FAULT, 8'h00, 0);
    check("kick rd", 16'(rd_q[7]), 16'h0000);
  endtask

  task automatic t_pins();
    repeat (3 * PW) @(negedge clk);
    core_status.phase = PH_CHARGING;
    repeat (PW + 10) @(negedge clk);
    check("charging", 16'(stat_oe), 16'h0001);
    core_status.phase = PH_DONE;
    repeat (4) @(negedge clk);
    check("done", 16'(stat_oe), 16'h0000);
    rw(1'b1, OFS_CONTROL, 8'h04, 0);
    @(negedge clk);
    core_status.phase = PH_CHARGING;
    repeat (6) @(negedge clk);
    check("masked", 16'(stat_oe), 16'h0000);
    core_status.supply_cond_code = 2'h1;
    pulse_len();
    check("pulse", 16'(len), 16'(PW));
    repeat (6) @(negedge clk);
    check("one pulse", 16'(stat_oe), 16'h0000);
    core_status.fault = FLT_THERMAL;
    pulse_len();
    check("pulse two", 16'(len), 16'(PW));
  endtask

  initial begin
    rst_n = 1'b0;
    core_status = '0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    t_reset();
    t_codes();
    t_rw();
    t_soft_reset();
    t_kick();
    t_pins();
    report_and_stop();
  end
endmodule
